// ---- rtl/cps_map.vh ----
/*
 * Step word layout, step kinds and timing constants of the profile sequencer.
 * Assumes inclusion by bare name from the sequencer and its ramp divider.
 */
`ifndef CPS_MAP_VH
`define CPS_MAP_VH

// Step word
`define CPS_STEP_W        144
`define CPS_KIND_LSB      0
`define CPS_KIND_W        3
`define CPS_KIND_SETPT    3'h0
`define CPS_KIND_LOOP     3'h1
`define CPS_KIND_HOLD     3'h2
`define CPS_KIND_DELAY    3'h3
`define CPS_KIND_STOP     3'h4

// Setpoint and hold fields
`define CPS_TGT_LSB       8
`define CPS_CH_W          16
`define CPS_PRES_BIT      72
`define CPS_OFF_LSB       73
`define CPS_MON_LSB       72
`define CPS_DUR_LSB       76
`define CPS_DUR_W         24
`define CPS_EVT_LSB       100
`define CPS_DRIER_BIT     106
`define CPS_AMB_BIT       107
`define CPS_PURGE_BIT     108
`define CPS_DI_LSB        112
`define CPS_DI_IGNORE     2'h0
`define CPS_DI_ON         2'h1
`define CPS_DI_OFF        2'h2

// Loop fields
`define CPS_LOOP_TGT_LSB  8
`define CPS_LOOP_CNT_LSB  16
`define CPS_LOOP_CNT_W    16
`define CPS_LOOP_INF      16'hFFFF
`define CPS_LOOP_MAX      16'h00FF

// Delayed start fields
`define CPS_DLY_ABS_BIT   8
`define CPS_DLY_DAY_LSB   9
`define CPS_DLY_TOD_LSB   12
`define CPS_DLY_TOD_W     17

// Stop field
`define CPS_STOP_HOLD_BIT 8

// Timing
`define CPS_TICK_MS       1000
`define CPS_CLK_KHZ       50000
`define CPS_TICK_CYCLES   (`CPS_TICK_MS * `CPS_CLK_KHZ)

`endif

// ---- rtl/cps_ramp_div.v ----
/*
 * One channel of ramp interpolation: value = start + (end - start) * elapsed / dur,
 * by a restoring divider started on each go pulse.
 * Assumes inputs stay steady while busy and elapsed never exceeds dur.
 */
`timescale 1ns/1ps
`include "cps_map.vh"

module cps_ramp_div #(
    parameter VW = 16,
    parameter TW = 24
) (
    input  wire          clk_i,
    input  wire          rst_n_i,
    input  wire          go_i,
    input  wire [VW-1:0] start_i,
    input  wire [VW-1:0] end_i,
    input  wire [TW-1:0] dur_i,
    input  wire [TW-1:0] elapsed_i,
    output reg  [VW-1:0] value_o,
    output reg           done_o
);

localparam PW = VW + 1 + TW;
localparam CW = 7;
localparam [CW-1:0] ITER = PW;

wire [VW:0]   diff    = {end_i[VW-1], end_i} - {start_i[VW-1], start_i};
wire [VW:0]   mag     = diff[VW] ? (~diff + 1'b1) : diff;
wire [PW-1:0] prod    = mag * elapsed_i;

reg           busy_q;
reg  [CW-1:0] cnt_q;
reg  [PW-1:0] num_q;
reg  [PW-1:0] quo_q;
reg  [TW:0]   rem_q;
reg  [TW-1:0] dur_q;
reg  [VW-1:0] base_q;
reg           neg_q;

wire [TW:0]   rem_t   = {rem_q[TW-1:0], num_q[PW-1]};
wire          fits    = rem_t >= {1'b0, dur_q};
wire [VW:0]   q_lo    = quo_q[VW:0];
wire [VW:0]   res     = neg_q ? ({base_q[VW-1], base_q} - q_lo) : ({base_q[VW-1], base_q} + q_lo);

////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_i)
begin
    if (!rst_n_i)
    begin
        busy_q  <= 1'b0;
        cnt_q   <= {CW{1'b0}};
        num_q   <= {PW{1'b0}};
        quo_q   <= {PW{1'b0}};
        rem_q   <= {(TW+1){1'b0}};
        dur_q   <= {TW{1'b0}};
        base_q  <= {VW{1'b0}};
        neg_q   <= 1'b0;
        value_o <= {VW{1'b0}};
        done_o  <= 1'b0;
    end
    else
    begin
        done_o <= 1'b0;
        if (go_i)
        begin
            busy_q <= 1'b1;
            cnt_q  <= ITER;
            num_q  <= prod;
            quo_q  <= {PW{1'b0}};
            rem_q  <= {(TW+1){1'b0}};
            dur_q  <= dur_i;
            base_q <= start_i;
            neg_q  <= diff[VW];
        end
        else if (busy_q && cnt_q != {CW{1'b0}})
        begin
            num_q <= {num_q[PW-2:0], 1'b0};
            quo_q <= {quo_q[PW-2:0], fits};
            rem_q <= fits ? (rem_t - {1'b0, dur_q}) : rem_t;
            cnt_q <= cnt_q - 1'b1;
        end
        else if (busy_q)
        begin
            // Result lies between start and end, so the low bits suffice
            value_o <= res[VW-1:0];
            done_o  <= 1'b1;
            busy_q  <= 1'b0;
        end
    end
end

endmodule

// ---- rtl/cps_seq.v ----
/*
 * Chamber profile step sequencer: runs a stored profile one step at a time and
 * drives channel setpoints, events, drier, ambient coil mode and purge.
 * Assumes the program is written while idle, inputs are synchronous to clk_i,
 * and day and time of day come from an external calendar.
 */
`timescale 1ns/1ps
`include "cps_map.vh"

module cps_seq #(
    parameter AW          = 8,
    parameter TICK_CYCLES = `CPS_TICK_CYCLES
) (
    input  wire                   clk_i,
    input  wire                   rst_n_i,
    input  wire                   prog_we_i,
    input  wire [AW-1:0]          prog_addr_i,
    input  wire [`CPS_STEP_W-1:0] prog_wdata_i,
    input  wire [AW-1:0]          last_step_i,
    input  wire                   run_i,
    input  wire                   stop_i,
    input  wire [3:0]             chan_present_i,
    input  wire                   humidity_chamber_i,
    input  wire                   drier_fitted_i,
    input  wire                   purge_present_i,
    input  wire                   purge_feature_enable_i,
    input  wire [63:0]            meas_i,
    input  wire [15:0]            di_i,
    input  wire [2:0]             day_i,
    input  wire [16:0]            tod_sec_i,
    output reg  [63:0]            setpoint_o,
    output reg  [3:0]             chan_on_o,
    output reg  [5:0]             event_o,
    output reg                    drier_select_o,
    output reg                    ambient_coil_proportional_select_o,
    output reg                    purge_output_enable_o,
    output reg                    chamber_on_o,
    output reg                    running_o,
    output reg                    steady_o,
    output reg                    step_error_o,
    output reg  [AW-1:0]          step_idx_o
);

localparam DEPTH = 1 << AW;
localparam TW    = $clog2(TICK_CYCLES);
localparam [TW-1:0] TICK_LAST = TICK_CYCLES - 1;

localparam [2:0] S_IDLE   = 3'h0;
localparam [2:0] S_FETCH  = 3'h1;
localparam [2:0] S_EXEC   = 3'h2;
localparam [2:0] S_RAMP   = 3'h3;
localparam [2:0] S_HOLD   = 3'h4;
localparam [2:0] S_DELAY  = 3'h5;
localparam [2:0] S_STEADY = 3'h6;

reg [`CPS_STEP_W-1:0] mem_q [0:DEPTH-1];
reg [7:0]             rem_q [0:DEPTH-1];
reg [DEPTH-1:0]       armed_q;

reg [2:0]             state_q;
reg [`CPS_STEP_W-1:0] step_q;
reg [TW-1:0]          tick_cnt_q;
reg [23:0]            run_sec_q;
reg [23:0]            elap_q;
reg [23:0]            hold_left_q;
reg                   final_q;
reg                   go_q;
reg                   met_q;
reg [3:0]             above_q;
reg [63:0]            start_q;
reg [63:0]            end_q;

wire                  tick    = tick_cnt_q == TICK_LAST;
wire [2:0]            kind    = step_q[`CPS_KIND_LSB +: `CPS_KIND_W];
wire [23:0]           dur     = step_q[`CPS_DUR_LSB +: `CPS_DUR_W];
wire [AW-1:0]         ltgt    = step_q[`CPS_LOOP_TGT_LSB +: AW];
wire [15:0]           lcnt    = step_q[`CPS_LOOP_CNT_LSB +: `CPS_LOOP_CNT_W];
wire                  at_end  = step_idx_o == last_step_i;
wire [3:0]            on_new  = {chan_present_i[3:1], 1'b1} & ~{step_q[`CPS_OFF_LSB +: 3], 1'b0};
wire [63:0]           div_val;
wire [3:0]            div_done;
wire [3:0]            reach;
wire [3:0]            now_above;
wire [3:0]            tgt_mask;
wire [15:0]           di_ok;
wire [63:0]           sp_next;

wire                  loop_ok = (ltgt < step_idx_o) &&
                                ((lcnt == `CPS_LOOP_INF) || (lcnt != 16'h0000 && lcnt <= `CPS_LOOP_MAX));
wire                  loop_inf  = lcnt == `CPS_LOOP_INF;
// first visit jumps, then count minus one more
wire                  loop_jump = loop_inf || !armed_q[step_idx_o] || rem_q[step_idx_o] != 8'h00;

wire                  dly_met = step_q[`CPS_DLY_ABS_BIT] ?
                                (day_i == step_q[`CPS_DLY_DAY_LSB +: 3] &&
                                 tod_sec_i >= step_q[`CPS_DLY_TOD_LSB +: `CPS_DLY_TOD_W]) :
                                (run_sec_q >= dur);
wire                  cond_ok = (&reach) && (&di_ok);

////////////////////////////////////////////////////////////////////////////////
genvar g;
generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_ch
        wire signed [15:0] meas = meas_i[16*g +: 16];
        wire signed [15:0] thr  = step_q[`CPS_TGT_LSB + 16*g +: 16];
        assign now_above[g] = meas > thr;
        assign reach[g] = !step_q[`CPS_MON_LSB + g] || (above_q[g] ? (meas <= thr) : (meas > thr));
        assign tgt_mask[g] = on_new[g];
        assign sp_next[16*g +: 16] = on_new[g] ? thr : setpoint_o[16*g +: 16];
        cps_ramp_div #(
            .VW (16),
            .TW (24)
        ) u_div (
            .clk_i     (clk_i),
            .rst_n_i   (rst_n_i),
            .go_i      (go_q),
            .start_i   (start_q[16*g +: 16]),
            .end_i     (end_q[16*g +: 16]),
            .dur_i     (dur),
            .elapsed_i (elap_q),
            .value_o   (div_val[16*g +: 16]),
            .done_o    (div_done[g])
        );
    end
    for (g = 0; g < 16; g = g + 1)
    begin : g_di
        wire [1:0] mode = step_q[`CPS_DI_LSB + 2*g +: 2];
        // ignore unless a level is required
        assign di_ok[g] = (mode == `CPS_DI_ON)  ? di_i[g] :
                          (mode == `CPS_DI_OFF) ? !di_i[g] : 1'b1;
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
integer i;
always @(posedge clk_i)
begin
    if (!rst_n_i)
    begin
        state_q      <= S_IDLE;
        step_q       <= {`CPS_STEP_W{1'b0}};
        armed_q      <= {DEPTH{1'b0}};
        tick_cnt_q   <= {TW{1'b0}};
        run_sec_q    <= 24'h000000;
        elap_q       <= 24'h000000;
        hold_left_q  <= 24'h000000;
        final_q      <= 1'b0;
        go_q         <= 1'b0;
        met_q        <= 1'b0;
        above_q      <= 4'h0;
        start_q      <= 64'h0000000000000000;
        end_q        <= 64'h0000000000000000;
        setpoint_o   <= 64'h0000000000000000;
        chan_on_o    <= 4'h0;
        event_o      <= 6'h00;
        drier_select_o <= 1'b0;
        ambient_coil_proportional_select_o <= 1'b0;
        purge_output_enable_o <= 1'b0;
        chamber_on_o <= 1'b0;
        running_o    <= 1'b0;
        steady_o     <= 1'b0;
        step_error_o <= 1'b0;
        step_idx_o   <= {AW{1'b0}};
    end
    else
    begin
        go_q       <= 1'b0;
        tick_cnt_q <= tick ? {TW{1'b0}} : tick_cnt_q + 1'b1;
        if (tick && run_sec_q != 24'hFFFFFF)
            run_sec_q <= run_sec_q + 24'h000001;

        case (state_q)
        S_IDLE:
        begin
            if (run_i)
            begin
                state_q      <= S_FETCH;
                step_idx_o   <= {AW{1'b0}};
                armed_q      <= {DEPTH{1'b0}};
                tick_cnt_q   <= {TW{1'b0}};
                run_sec_q    <= 24'h000000;
                step_error_o <= 1'b0;
                running_o    <= 1'b1;
                chamber_on_o <= 1'b1;
                chan_on_o    <= 4'h1;
            end
        end
        S_FETCH:
        begin
            step_q  <= mem_q[step_idx_o];
            state_q <= S_EXEC;
        end
        S_EXEC:
        begin
            case (kind)
            `CPS_KIND_SETPT:
            begin
                if (!step_q[`CPS_PRES_BIT])
                    state_q <= S_IDLE;
                else
                begin
                    event_o <= step_q[`CPS_EVT_LSB +: 6];
                    drier_select_o <= step_q[`CPS_DRIER_BIT] && humidity_chamber_i && drier_fitted_i;
                    ambient_coil_proportional_select_o <= step_q[`CPS_AMB_BIT];
                    // purge gated by device and feature
                    purge_output_enable_o <= step_q[`CPS_PURGE_BIT] && purge_present_i &&
                                             purge_feature_enable_i;
                    chan_on_o <= tgt_mask;
                    if (dur == 24'h000000)
                    begin
                        setpoint_o <= sp_next;
                        state_q    <= at_end ? S_IDLE : S_FETCH;
                        step_idx_o <= step_idx_o + 1'b1;
                    end
                    else
                    begin
                        start_q    <= setpoint_o;
                        end_q      <= sp_next;
                        elap_q     <= 24'h000000;
                        final_q    <= 1'b0;
                        tick_cnt_q <= {TW{1'b0}};
                        state_q    <= S_RAMP;
                    end
                end
            end
            `CPS_KIND_LOOP:
            begin
                if (!loop_ok)
                    state_q <= S_IDLE;
                else if (loop_jump)
                begin
                    if (!loop_inf && !armed_q[step_idx_o])
                    begin
                        armed_q[step_idx_o] <= 1'b1;
                        rem_q[step_idx_o]   <= lcnt[7:0] - 8'h01;
                    end
                    else if (!loop_inf)
                        rem_q[step_idx_o] <= rem_q[step_idx_o] - 8'h01;
                    step_idx_o <= ltgt;
                    state_q    <= S_FETCH;
                end
                else
                begin
                    armed_q[step_idx_o] <= 1'b0;
                    state_q    <= at_end ? S_IDLE : S_FETCH;
                    step_idx_o <= step_idx_o + 1'b1;
                end
            end
            `CPS_KIND_HOLD:
            begin
                above_q     <= now_above;
                met_q       <= 1'b0;
                hold_left_q <= dur;
                state_q     <= S_HOLD;
            end
            `CPS_KIND_DELAY:
            begin
                chamber_on_o <= 1'b0;
                state_q      <= S_DELAY;
            end
            `CPS_KIND_STOP:
            begin
                if (step_q[`CPS_STOP_HOLD_BIT])
                begin
                    steady_o <= 1'b1;
                    state_q  <= S_STEADY;
                end
                else
                    state_q <= S_IDLE;
            end
            default:
                state_q <= S_IDLE;
            endcase
            if (kind > `CPS_KIND_STOP ||
                (kind == `CPS_KIND_SETPT && !step_q[`CPS_PRES_BIT]) ||
                (kind == `CPS_KIND_LOOP && !loop_ok))
                step_error_o <= 1'b1;
        end
        S_RAMP:
        begin
            if (tick)
            begin
                elap_q  <= elap_q + 24'h000001;
                final_q <= (elap_q + 24'h000001) == dur;
                go_q    <= 1'b1;
            end
            if (div_done[0])
            begin
                for (i = 0; i < 4; i = i + 1)
                    setpoint_o[16*i +: 16] <= div_val[16*i +: 16];
                if (final_q)
                begin
                    state_q    <= at_end ? S_IDLE : S_FETCH;
                    step_idx_o <= step_idx_o + 1'b1;
                end
            end
        end
        S_HOLD:
        begin
            // timer runs only once conditions met
            if (cond_ok)
                met_q <= 1'b1;
            if ((met_q || cond_ok) && hold_left_q == 24'h000000)
            begin
                state_q    <= at_end ? S_IDLE : S_FETCH;
                step_idx_o <= step_idx_o + 1'b1;
            end
            else if (met_q && tick)
                hold_left_q <= hold_left_q - 24'h000001;
        end
        S_DELAY:
        begin
            if (dly_met)
            begin
                chamber_on_o <= 1'b1;
                state_q      <= at_end ? S_IDLE : S_FETCH;
                step_idx_o   <= step_idx_o + 1'b1;
            end
        end
        S_STEADY:
        begin
            state_q <= S_STEADY;
        end
        default:
            state_q <= S_IDLE;
        endcase

        // shutdown on end, error, stop step without hold or manual stop
        if ((state_q != S_IDLE && stop_i) || (state_q == S_EXEC && kind != `CPS_KIND_STOP && 1'b0))
            state_q <= S_IDLE;
        if (state_q != S_IDLE && (stop_i || state_q_next_idle(state_q, kind)))
        begin
            state_q        <= S_IDLE;
            chamber_on_o   <= 1'b0;
            running_o      <= 1'b0;
            steady_o       <= 1'b0;
            chan_on_o      <= 4'h0;
            event_o        <= 6'h00;
            drier_select_o <= 1'b0;
            ambient_coil_proportional_select_o <= 1'b0;
            purge_output_enable_o <= 1'b0;
        end
    end
end

// Predicts the cycles where the case above falls back to idle
function state_q_next_idle;
    input [2:0] st;
    input [2:0] kd;
    begin
        state_q_next_idle = 1'b0;
        if (st == S_EXEC)
            state_q_next_idle = (kd > `CPS_KIND_STOP) ||
                (kd == `CPS_KIND_SETPT && (!step_q[`CPS_PRES_BIT] || (dur == 24'h000000 && at_end))) ||
                (kd == `CPS_KIND_LOOP && (!loop_ok || (!loop_jump && at_end))) ||
                (kd == `CPS_KIND_STOP && !step_q[`CPS_STOP_HOLD_BIT]);
        else if (st == S_RAMP)
            state_q_next_idle = div_done[0] && final_q && at_end;
        else if (st == S_HOLD)
            state_q_next_idle = (met_q || cond_ok) && hold_left_q == 24'h000000 && at_end;
        else if (st == S_DELAY)
            state_q_next_idle = dly_met && at_end;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Program store, no read port conflict since writes are expected while idle
always @(posedge clk_i)
begin
    if (prog_we_i)
        mem_q[prog_addr_i] <= prog_wdata_i;
end

endmodule

// ---- bench/cps_seq_monitor.sv ----
/*
 * Port-level assertions for the profile sequencer.
 * Assumes a bind onto cps_seq, one clock, synchronous active-low reset.
 */
`timescale 1ns/1ps
module cps_seq_monitor (
    input wire        clk_i,
    input wire        rst_n_i,
    input wire        run_i,
    input wire        stop_i,
    input wire        humidity_chamber_i,
    input wire        drier_fitted_i,
    input wire        purge_present_i,
    input wire        purge_feature_enable_i,
    input wire [63:0] setpoint_o,
    input wire [5:0]  event_o,
    input wire        drier_select_o,
    input wire        purge_output_enable_o,
    input wire        chamber_on_o,
    input wire        running_o,
    input wire        steady_o,
    input wire        step_error_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_start;
        !running_o && !steady_o && run_i && !stop_i;
    endsequence
    sequence s_stop;
        running_o && stop_i;
    endsequence
    a_run_start: assert property (s_start |-> ##[1:2] running_o)
        else $error("run request not taken");
    a_stop_shuts: assert property (s_stop |=> !running_o && !chamber_on_o)
        else $error("manual stop did not shut down");
    a_error_shuts: assert property ($rose(step_error_o) |-> ##[0:1] (!running_o && !chamber_on_o))
        else $error("invalid step did not shut down");
    a_error_sticky: assert property (step_error_o && !run_i |=> step_error_o)
        else $error("step error cleared early");
    a_drier_gate: assert property (drier_select_o |-> humidity_chamber_i && drier_fitted_i)
        else $error("drier selected without drier");
    a_purge_gate: assert property (purge_output_enable_o |-> purge_present_i && purge_feature_enable_i)
        else $error("purge on while not enabled");
    a_idle_quiet: assert property (!running_o && !steady_o |-> event_o == 6'h00 && !purge_output_enable_o)
        else $error("outputs left on after shutdown");
    a_idle_hold_sp: assert property (!running_o && !steady_o |=> $stable(setpoint_o))
        else $error("setpoint moved while idle");
    a_steady_keep: assert property (steady_o && !stop_i |=> $stable(setpoint_o))
        else $error("steady setpoint moved");
    a_steady_on: assert property (steady_o |-> chamber_on_o)
        else $error("steady state without chamber on");
endmodule
bind cps_seq cps_seq_monitor cps_seq_monitor_inst (.*);

// ---- bench/cps_plant.sv ----
/*
 * Chamber model: sensors and digital inputs seen by the sequencer.
 * Assumes the bench sets a sensor offset and the contact states.
 */
`timescale 1ns/1ps
module cps_plant (
    input  wire [63:0] setpoint_i,
    input  wire [15:0] bias_i,
    input  wire [15:0] di_set_i,
    output wire [63:0] meas_o,
    output wire [15:0] di_o
);
    // Ideal plant plus offset on channel 0, so its hold threshold is crossed on command
    assign meas_o = {setpoint_i[63:16], setpoint_i[15:0] + bias_i};
    assign di_o   = di_set_i;
endmodule

// ---- bench/test_cps_seq.sv ----
/*
 * Self-checking bench for the profile sequencer.
 * Assumes a 100-cycle tick so ramps and holds stay short.
 */
`timescale 1ns/1ps
module test_cps_seq;
    reg          clk_i = 0, rst_n_i = 0, prog_we_i = 0, run_i = 0, stop_i = 0, mid_seen = 0;
    reg  [7:0]   prog_addr_i = 0, last_step_i = 0;
    reg  [143:0] prog_wdata_i = 0;
    reg  [15:0]  bias = 0, di_set = 0;
    reg  [3:0]   cfg = 4'h7;
    wire [63:0]  setpoint_o, meas_i;
    wire [15:0]  di_i;
    wire [7:0]   step_idx_o;
    wire [5:0]   event_o;
    wire [3:0]   chan_on_o;
    wire         drier_o, amb_o, purge_o, chamber_on_o, running_o, steady_o, step_error_o;
    integer      n_errors = 0, cmp_count = 0, i;
    cps_seq #(.TICK_CYCLES(100)) cps_seq_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .prog_we_i(prog_we_i),
        .prog_addr_i(prog_addr_i), .prog_wdata_i(prog_wdata_i), .last_step_i(last_step_i), .run_i(run_i),
        .stop_i(stop_i), .chan_present_i(4'h3), .humidity_chamber_i(cfg[0]), .drier_fitted_i(cfg[1]),
        .purge_present_i(cfg[2]), .purge_feature_enable_i(cfg[3]), .meas_i(meas_i), .di_i(di_i),
        .day_i(3'h0), .tod_sec_i(17'h00000), .setpoint_o(setpoint_o), .chan_on_o(chan_on_o),
        .event_o(event_o), .drier_select_o(drier_o), .ambient_coil_proportional_select_o(amb_o),
        .purge_output_enable_o(purge_o), .chamber_on_o(chamber_on_o), .running_o(running_o),
        .steady_o(steady_o), .step_error_o(step_error_o), .step_idx_o(step_idx_o));
    cps_plant cps_plant_inst (.setpoint_i(setpoint_o), .bias_i(bias), .di_set_i(di_set), .meas_o(meas_i),
        .di_o(di_i));
    always #10 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////
    function [143:0] sp(input [15:0] t, input [23:0] d, input [8:0] x);
        begin
            sp = 144'h0;
            sp[8 +: 16] = t;
            sp[72] = 1'b1;
            sp[76 +: 24] = d;
            sp[100 +: 9] = x;
        end
    endfunction
    function [143:0] lp(input [7:0] t, input [15:0] c);
        lp = {112'h0, c, t, 8'h01};
    endfunction
    task chk(input [63:0] got, input [63:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp)
            begin
                n_errors = n_errors + 1;
                $display("Error %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
            if (n_errors == 0 && cmp_count > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task wr(input [7:0] a, input [143:0] w);
        begin
            @(negedge clk_i);
            prog_addr_i = a;
            prog_wdata_i = w;
            prog_we_i = 1'b1;
            @(negedge clk_i);
            prog_we_i = 1'b0;
        end
    endtask
    task start(input [7:0] last);
        begin
            last_step_i = last;
            run_i = 1'b1;
            @(negedge clk_i);
            run_i = 1'b0;
        end
    endtask
    // Mode 0 waits for a step index, mode 1 for the end of the run
    task wait_c(input integer m, input [7:0] v);
        integer k;
        begin
            k = 0;
            while ((m == 0 ? step_idx_o !== v : running_o !== 1'b0) && k < 1000)
            begin
                @(negedge clk_i);
                k = k + 1;
                if (setpoint_o[15:0] === 16'h0058)
                    mid_seen = 1'b1;
            end
            if (k == 1000)
            begin
                n_errors = n_errors + 1;
                $display("Error %0t: wait ran out", $time);
                wrap_up;
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(negedge clk_i);
        rst_n_i = 1'b1;
        wr(0, sp(16'h0050, 24'h0, 9'h000));
        wr(1, sp(16'h0060, 24'h2, 9'h1EA));
        wr(2, sp(16'h0070, 24'h0, 9'h0) | (144'h1 << 112) | 144'h2);
        wr(3, lp(8'h01, 16'h0001));
        wr(4, 144'h104);
        start(4);
        wait_c(0, 1);
        repeat (3) @(negedge clk_i);
        chk(setpoint_o[15:0], 16'h0050);
        chk(event_o, 6'h2A);
        chk({drier_o, amb_o, purge_o}, 3'h6);
        chk(chan_on_o, 4'h3);
        wait_c(0, 2);
        chk(setpoint_o[15:0], 16'h0060);
        chk(mid_seen, 1'b1);
        repeat (20) @(negedge clk_i);
        chk(step_idx_o, 8'h02);
        bias = 16'h0020;
        repeat (20) @(negedge clk_i);
        chk(step_idx_o, 8'h02);
        di_set = 16'h0001;
        wait_c(0, 1);
        wait_c(0, 2);
        repeat (20) @(negedge clk_i);
        chk(step_idx_o, 8'h02);
        bias = 16'h0000;
        wait_c(0, 4);
        repeat (3) @(negedge clk_i);
        chk({steady_o, chamber_on_o, setpoint_o[15:0]}, {2'h3, 16'h0060});
        stop_i = 1'b1;
        @(negedge clk_i);
        stop_i = 1'b0;
        // Missing target, loop to itself, count 0, count 256, unknown kind
        for (i = 0; i < 5; i = i + 1)
        begin
            wr(0, i == 0 ? sp(16'h0010, 24'h0, 9'h0) & ~(144'h1 << 72) : i == 1 ? lp(8'h00, 16'h0001) :
                i == 4 ? 144'h5 : sp(16'h0010, 24'h0, 9'h0));
            wr(1, lp(8'h00, i == 3 ? 16'h0100 : 16'h0000));
            start(1);
            repeat (8) @(negedge clk_i);
            chk({step_error_o, running_o}, 2'h2);
        end
        cfg = 4'hF;
        wr(0, sp(16'h0030, 24'h0, 9'h100));
        wr(1, lp(8'h00, 16'hFFFF));
        start(1);
        repeat (60) @(negedge clk_i);
        chk({running_o, purge_o}, 2'h3);
        stop_i = 1'b1;
        @(negedge clk_i);
        stop_i = 1'b0;
        @(negedge clk_i);
        chk(chamber_on_o, 1'b0);
        // Relative delayed start of one second, then a setpoint step
        wr(0, 144'h3 | (144'h1 << 76));
        wr(1, sp(16'h0020, 24'h0, 9'h0));
        start(1);
        repeat (4) @(negedge clk_i);
        chk({running_o, chamber_on_o}, 2'h2);
        wait_c(1, 0);
        chk(setpoint_o[15:0], 16'h0020);
        wr(0, sp(16'h0040, 24'h0, 9'h0));
        start(0);
        wait_c(1, 0);
        chk({chamber_on_o, setpoint_o[15:0]}, {1'b0, 16'h0040});
        wrap_up;
    end
endmodule
